// file: testbench/eb_enclave_build_properties.sv
`timescale 1ns/1ps
module eb_enclave_build_properties
  import eb_pkg::*;
#(
  parameter int PAGE_AW = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // page copy request
  input wire logic copy_req_o,
  input wire logic [31:0] copy_src_o,
  input wire logic [PAGE_AW-1:0] copy_page_o
);
  logic [3:0] since_add_reg;
  logic rd_ack;
  logic add_taken;
  assign rd_ack = ack_o && !we_i;
  assign add_taken = cyc_i && stb_i && !ack_o && we_i && sel_i[0] &&
    adr_i == EB_CTRL_OFS && dat_i[2:0] == 3'h2;

  // saturating age of the last add request, bounds the copy pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      since_add_reg <= 4'hf;
    else if (add_taken)
      since_add_reg <= 4'h0;
    else if (since_add_reg != 4'hf)
      since_add_reg <= since_add_reg + 4'h1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_info_lo_resv: assert property (rd_ack && adr_i == EB_INFO_LO_OFS
    |-> dat_o[31:16] == 16'h0 && dat_o[7:6] == 2'h0)
    else $error("reserved low status bits not zero");
  a_info_hi_resv: assert property (rd_ack && adr_i == EB_INFO_HI_OFS
    |-> dat_o[30:0] == 31'h0)
    else $error("reserved high status bits not zero");
  a_unmapped_zero: assert property (rd_ack &&
    (adr_i > EB_INFO_HI_OFS || adr_i[1:0] != 2'h0) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_enter_init: assert property (rd_ack && adr_i == EB_STAT_OFS
    && dat_o[14] |-> dat_o[15])
    else $error("entered without initialized bit");
  a_init_life: assert property (rd_ack && adr_i == EB_STAT_OFS
    |-> dat_o[15] == (dat_o[1:0] == 2'h2))
    else $error("initialized bit and lifecycle disagree");
  a_copy_pulse: assert property (copy_req_o |=> !copy_req_o)
    else $error("copy request longer than one cycle");
  a_copy_cause: assert property (copy_req_o |-> since_add_reg < 4'h6)
    else $error("copy request without a recent add");
  a_copy_hold: assert property ($changed(copy_src_o) ||
    $changed(copy_page_o) |-> copy_req_o)
    else $error("copy target changed without request");
endmodule

bind eb_enclave_build eb_enclave_build_properties #(.PAGE_AW(PAGE_AW))
  u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .copy_req_o(copy_req_o), .copy_src_o(copy_src_o),
  .copy_page_o(copy_page_o));

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import eb_pkg::*;
  localparam logic [31:0] BASE = 32'h00010000;
  localparam logic [31:0] SIZE = 32'h00004000;
  localparam logic [31:0] ATTR = 32'h00000004;
  localparam logic [31:0] MISC = 32'h00000003;
  localparam logic [31:0] KEY = 32'h13572468;
  localparam logic [31:0] PKEY = 32'h2468ace0;
  typedef struct packed
  {
    logic [5:0] page;
    logic [7:0] ptype;
    logic [2:0] perm;
    logic [31:0] lin;
    logic [3:0] err;
  } eb_add_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic copy_req_o;
  logic [31:0] copy_src_o;
  logic [5:0] copy_page_o;
  logic [31:0] rd, lo, hi, meas, last_src;
  logic [5:0] last_page;
  logic [31:0] info [64] = '{default: 32'h0};
  logic [3:0] errs [5] = '{EB_ERR_SIGN, EB_ERR_MEAS, EB_ERR_ATTR,
    EB_ERR_TOKEN, EB_ERR_NONE};
  // free page 3 out of range, page 1 reused, type 0 not addable
  eb_add_row_s rows [6] = '{
    '{6'h01, EB_TYPE_REG, 3'h3, BASE, EB_ERR_NONE},
    '{6'h02, EB_TYPE_THREAD, 3'h0, BASE + 32'h1000, EB_ERR_NONE},
    '{6'h03, EB_TYPE_REG, 3'h5, BASE + SIZE, EB_ERR_PAGE},
    '{6'h01, EB_TYPE_REG, 3'h1, BASE + 32'h2000, EB_ERR_PAGE},
    '{6'h04, EB_TYPE_CTRL, 3'h1, BASE + 32'h2000, EB_ERR_PAGE},
    '{6'h05, EB_TYPE_REG, 3'h7, BASE + 32'h3000, EB_ERR_NONE}};
  logic [3:0] lanes = 4'hf;
  int n_errors = 0;
  int checks = 0;
  int n_copy = 0;

  always #2.5 clk_i = ~clk_i;

  eb_enclave_build #(.PAGE_AW(6), .PLATFORM_KEY(PKEY)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .copy_req_o(copy_req_o), .copy_src_o(copy_src_o),
    .copy_page_o(copy_page_o));

  always @(posedge clk_i)
  begin
    if (copy_req_o === 1'b1)
    begin
      n_copy++;
      last_src = copy_src_o;
      last_page = copy_page_o;
    end
  end

  function automatic logic [31:0] mx(logic [31:0] a, logic [31:0] b);
    mx = {a[26:0], a[31:27]} ^ b ^ EB_MIX_K;
  endfunction

  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done(input string name);
    $display("test %s done, errors so far %0d", name, n_errors);
  endtask

  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= lanes;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack_o !== 1'b1 && i < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (ack_o !== 1'b1)
    begin
      n_errors++;
      $display("MISMATCH %0t bus cycle not acknowledged", $time);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic op(input logic [2:0] c, input logic [3:0] e);
    int i;
    wr(EB_CTRL_OFS, {29'h0, c});
    i = 0;
    do
    begin
      wb(1'b0, EB_STAT_OFS, 32'h0, rd);
      i++;
    end
    while ((rd[13] !== 1'b1 || rd[12] !== 1'b0) && i < 20);
    if (rd[13] !== 1'b1)
    begin
      n_errors++;
      $display("MISMATCH %0t operation never completed", $time);
      end_of_test();
    end
    chk({28'h0, rd[7:4]}, {28'h0, e});
  endtask

  task automatic rd_info(input logic [5:0] p);
    wr(EB_PAGE_SEL_OFS, {26'h0, p});
    wb(1'b0, EB_INFO_LO_OFS, 32'h0, lo);
    wb(1'b0, EB_INFO_HI_OFS, 32'h0, hi);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  initial
  begin
    eb_add_row_s r;
    int cnt;
    logic [31:0] src, ext, fin, h;
    do_reset();
    wb(1'b0, EB_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    wr(8'hfc, 32'hffffffff);
    wb(1'b0, 8'hfc, 32'h0, rd);
    chk(rd, 32'h0);
    op(EB_OP_ENTER, EB_ERR_ENTER);
    op(EB_OP_ADD, EB_ERR_STATE);
    op(3'h6, EB_ERR_OP);
    op(EB_OP_INIT, EB_ERR_STATE);
    op(EB_OP_EXTEND, EB_ERR_STATE);
    // only lane 0 may land
    lanes = 4'h1;
    wr(EB_LIN_ADDR_OFS, 32'hffffffff);
    lanes = 4'hf;
    wb(1'b0, EB_LIN_ADDR_OFS, 32'h0, rd);
    chk(rd, 32'h000000ff);
    test_done("before create");
    wr(EB_PAGE_SEL_OFS, 32'h0);
    wr(EB_BASE_OFS, BASE);
    wr(EB_SIZE_OFS, SIZE);
    wr(EB_ATTR_OFS, ATTR);
    wr(EB_MISC_OFS, MISC);
    wr(EB_SSA_OFS, 32'h1);
    op(EB_OP_CREATE, EB_ERR_NONE);
    meas = mx(mx(EB_LOG_SEED, BASE), SIZE ^ 32'h1);
    wb(1'b0, EB_STAT_OFS, 32'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h1);
    op(EB_OP_CREATE, EB_ERR_STATE);
    for (int i = 0; i < 6; i++)
    begin
      r = rows[i];
      cnt = n_copy;
      src = 32'h80000000 + 32'(i) * 32'h1000;
      wr(EB_PAGE_SEL_OFS, {26'h0, r.page});
      wr(EB_PAGE_ARG_OFS, {21'h0, r.ptype, r.perm});
      wr(EB_LIN_ADDR_OFS, r.lin);
      wr(EB_SRC_ADDR_OFS, src);
      op(EB_OP_ADD, r.err);
      chk(32'(n_copy - cnt), {31'h0, r.err == EB_ERR_NONE});
      if (r.err == EB_ERR_NONE)
      begin
        info[r.page] = {16'h0, r.ptype, 5'h0, r.perm};
        meas = mx(meas, {r.lin[31:12], 1'b0, r.perm, r.ptype});
        chk(last_src, src);
        chk({26'h0, last_page}, {26'h0, r.page});
      end
      rd_info(r.page);
      chk(lo, info[r.page]);
      chk(hi, 32'h0);
      test_done("add row");
    end
    wr(EB_PAGE_SEL_OFS, 32'h3);
    op(EB_OP_EXTEND, EB_ERR_PAGE);
    wr(EB_PAGE_SEL_OFS, 32'h1);
    for (int i = 0; i < EB_CHUNKS; i++)
    begin
      ext = 32'ha5000000 | 32'(i * 7);
      wr(EB_LIN_ADDR_OFS, BASE + 32'(i * EB_CHUNK_BYTES));
      wr(EB_EXT_DATA_OFS, ext);
      op(EB_OP_EXTEND, EB_ERR_NONE);
      meas = mx(mx(meas, {BASE[31:12], 4'(i), 8'h0}), ext);
    end
    wb(1'b0, EB_MEAS_OFS, 32'h0, rd);
    chk(rd, meas);
    test_done("extend page");
    fin = mx(meas, EB_FINAL_K);
    wr(EB_SIG_KEY_OFS, KEY);
    wr(EB_SIG_MISC_OFS, MISC);
    wr(EB_PRODID_OFS, 32'h00001234);
    wr(EB_SVN_OFS, 32'h00000007);
    for (int s = 0; s < 5; s++)
    begin
      h = fin ^ {31'h0, (s < 2)};
      wr(EB_SIG_HASH_OFS, h);
      wr(EB_SIG_SIGN_OFS, mx(KEY, h) ^ {31'h0, (s < 1)});
      wr(EB_SIG_ATTR_OFS, ATTR ^ {31'h0, (s < 3)});
      wr(EB_TOKEN_OFS, PKEY ^ h ^ {31'h0, (s < 4)});
      op(EB_OP_INIT, errs[s]);
    end
    wb(1'b0, EB_STAT_OFS, 32'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h2);
    chk({31'h0, rd[15]}, 32'h1);
    wb(1'b0, EB_IDENT_OFS, 32'h0, rd);
    chk(rd, fin);
    wb(1'b0, EB_AUTH_OFS, 32'h0, rd);
    chk(rd, mx(KEY, EB_FINAL_K));
    wb(1'b0, EB_PRODID_OFS, 32'h0, rd);
    chk(rd, 32'h00001234);
    wb(1'b0, EB_SVN_OFS, 32'h0, rd);
    chk(rd, 32'h00000007);
    test_done("init checks");
    op(EB_OP_ADD, EB_ERR_INITED);
    op(EB_OP_EXTEND, EB_ERR_INITED);
    op(EB_OP_ENTER, EB_ERR_NONE);
    chk({31'h0, rd[14]}, 32'h1);
    test_done("after init");
    do_reset();
    wb(1'b0, EB_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    rd_info(6'h01);
    chk(lo, 32'h0);
    op(EB_OP_ENTER, EB_ERR_ENTER);
    test_done("second reset");
    end_of_test();
  end
endmodule

// file: verilog/eb_enclave_build.sv
`timescale 1ns/1ps
module eb_enclave_build
  import eb_pkg::*;
#(
  parameter int PAGE_AW = 6,
  parameter logic [31:0] PLATFORM_KEY = 32'h5a5a0f0f // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // page copy request
  output logic copy_req_o,
  output logic [31:0] copy_src_o,
  output logic [PAGE_AW-1:0] copy_page_o
);

  typedef struct packed
  {
    logic ack;
    logic [31:0] rdat;
    eb_state_e state;
    eb_op_e op;
    eb_life_e life;
    logic [3:0] err;
    logic done;
    logic entered;
    logic attr_init;
    logic [PAGE_AW-1:0] page_sel;
    logic [PAGE_AW-1:0] ctrl_page;
    logic [10:0] page_arg;
    logic [31:0] lin_addr;
    logic [31:0] src_addr;
    logic [31:0] base;
    logic [31:0] size;
    logic [31:0] attr;
    logic [31:0] misc;
    logic [31:0] ssa;
    logic [31:0] ext_data;
    logic [31:0] sig_key;
    logic [31:0] sig_hash;
    logic [31:0] sig_attr;
    logic [31:0] sig_misc;
    logic [31:0] sig_sign;
    logic [31:0] token;
    logic [31:0] prodid;
    logic [31:0] svn;
    logic [31:0] meas;
    logic [31:0] ident;
    logic [31:0] auth;
    logic [31:0] rec_prodid;
    logic [31:0] rec_svn;
    logic copy_req;
    logic [31:0] copy_src;
    logic [PAGE_AW-1:0] copy_page;
  } eb_top_s;

  eb_top_s st_reg;
  eb_top_s st_next;
  eb_map_entry_s cur;
  eb_map_entry_s new_ent;
  logic [63:0] info;
  logic [31:0] final_meas;
  logic req;

  eb_map_if #(.AW(PAGE_AW), .W(EB_ENTRY_W)) map ();

  eb_page_map #(.AW(PAGE_AW), .W(EB_ENTRY_W)) u_map (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .map(map)
  );

  // byte-lane merge for writes
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] din,
    logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign cur = eb_map_entry_s'(map.rdata);
  assign req = cyc_i && stb_i && !st_reg.ack;
  assign final_meas = eb_mix(st_reg.meas, EB_FINAL_K);
  assign map.raddr = st_reg.page_sel;

  // page status word, reserved bits forced low
  always_comb
  begin
    info = '0;
    info[EB_INFO_R_BIT] = cur.perm[0];
    info[EB_INFO_W_BIT] = cur.perm[1];
    info[EB_INFO_X_BIT] = cur.perm[2];
    info[EB_INFO_PEND_BIT] = cur.pending;
    info[EB_INFO_MOD_BIT] = cur.modified;
    info[EB_INFO_RSTR_BIT] = cur.restricted;
    info[EB_INFO_TYPE_LSB +: 8] = cur.ptype;
    info[EB_INFO_BLK_BIT] = cur.blocked;
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.ack = req;
    st_next.copy_req = 1'b0;
    map.we = 1'b0;
    map.waddr = st_reg.page_sel;
    new_ent = '0;
    new_ent.valid = 1'b1;
    new_ent.perm = st_reg.page_arg[2:0];
    new_ent.ptype = st_reg.page_arg[10:3];
    new_ent.lin_page = st_reg.lin_addr[31:12];
    map.wdata = new_ent;

    // register reads
    if (req && !we_i)
    begin
      unique case (adr_i)
        EB_STAT_OFS:
          st_next.rdat = {16'h0, st_reg.attr_init, st_reg.entered,
            st_reg.done, (st_reg.state != EB_ST_IDLE), 4'h0, st_reg.err,
            2'h0, st_reg.life};
        EB_PAGE_SEL_OFS: st_next.rdat = 32'(st_reg.page_sel);
        EB_PAGE_ARG_OFS: st_next.rdat = 32'(st_reg.page_arg);
        EB_LIN_ADDR_OFS: st_next.rdat = st_reg.lin_addr;
        EB_SRC_ADDR_OFS: st_next.rdat = st_reg.src_addr;
        EB_BASE_OFS: st_next.rdat = st_reg.base;
        EB_SIZE_OFS: st_next.rdat = st_reg.size;
        EB_ATTR_OFS: st_next.rdat = st_reg.attr;
        EB_MISC_OFS: st_next.rdat = st_reg.misc;
        EB_SSA_OFS: st_next.rdat = st_reg.ssa;
        EB_MEAS_OFS: st_next.rdat = st_reg.meas;
        EB_IDENT_OFS: st_next.rdat = st_reg.ident;
        EB_AUTH_OFS: st_next.rdat = st_reg.auth;
        EB_PRODID_OFS: st_next.rdat = st_reg.rec_prodid;
        EB_SVN_OFS: st_next.rdat = st_reg.rec_svn;
        EB_INFO_LO_OFS: st_next.rdat = info[31:0];
        EB_INFO_HI_OFS: st_next.rdat = info[63:32];
        default: st_next.rdat = 32'h0;
      endcase
    end

    // register writes; argument writes while busy are dropped
    if (req && we_i && st_reg.state == EB_ST_IDLE)
    begin
      unique case (adr_i)
        EB_CTRL_OFS:
        begin
          if (sel_i[0])
          begin
            st_next.op = eb_op_e'(dat_i[2:0]);
            st_next.state = EB_ST_SETTLE;
            st_next.done = 1'b0;
            st_next.err = EB_ERR_NONE;
          end
        end
        EB_PAGE_SEL_OFS:
          st_next.page_sel = PAGE_AW'(merge(32'(st_reg.page_sel), dat_i,
            sel_i));
        EB_PAGE_ARG_OFS:
          st_next.page_arg = 11'(merge(32'(st_reg.page_arg), dat_i, sel_i));
        EB_LIN_ADDR_OFS:
          st_next.lin_addr = merge(st_reg.lin_addr, dat_i, sel_i);
        EB_SRC_ADDR_OFS:
          st_next.src_addr = merge(st_reg.src_addr, dat_i, sel_i);
        EB_BASE_OFS: st_next.base = merge(st_reg.base, dat_i, sel_i);
        EB_SIZE_OFS: st_next.size = merge(st_reg.size, dat_i, sel_i);
        EB_ATTR_OFS: st_next.attr = merge(st_reg.attr, dat_i, sel_i);
        EB_MISC_OFS: st_next.misc = merge(st_reg.misc, dat_i, sel_i);
        EB_SSA_OFS: st_next.ssa = merge(st_reg.ssa, dat_i, sel_i);
        EB_EXT_DATA_OFS:
          st_next.ext_data = merge(st_reg.ext_data, dat_i, sel_i);
        EB_SIG_KEY_OFS:
          st_next.sig_key = merge(st_reg.sig_key, dat_i, sel_i);
        EB_SIG_HASH_OFS:
          st_next.sig_hash = merge(st_reg.sig_hash, dat_i, sel_i);
        EB_SIG_ATTR_OFS:
          st_next.sig_attr = merge(st_reg.sig_attr, dat_i, sel_i);
        EB_SIG_MISC_OFS:
          st_next.sig_misc = merge(st_reg.sig_misc, dat_i, sel_i);
        EB_SIG_SIGN_OFS:
          st_next.sig_sign = merge(st_reg.sig_sign, dat_i, sel_i);
        EB_TOKEN_OFS: st_next.token = merge(st_reg.token, dat_i, sel_i);
        EB_PRODID_OFS: st_next.prodid = merge(st_reg.prodid, dat_i, sel_i);
        EB_SVN_OFS: st_next.svn = merge(st_reg.svn, dat_i, sel_i);
        default:
        begin
        end
      endcase
    end

    // settle lets the map read of page_sel catch up with a recent write
    unique case (st_reg.state)
      EB_ST_IDLE:
      begin
      end
      EB_ST_SETTLE:
        st_next.state = EB_ST_EXEC;
      EB_ST_EXEC:
      begin
        st_next.state = EB_ST_IDLE;
        st_next.done = 1'b1;
        unique case (st_reg.op)
          EB_OP_CREATE:
          begin
            if (st_reg.life != EB_LC_EMPTY)
              st_next.err = EB_ERR_STATE;
            else if (cur.valid)
              st_next.err = EB_ERR_PAGE;
            else
            begin
              // control page holds the enclave layout registers
              new_ent.ptype = EB_TYPE_CTRL;
              new_ent.perm = 3'h0;
              new_ent.lin_page = '0;
              map.wdata = new_ent;
              map.we = 1'b1;
              st_next.ctrl_page = st_reg.page_sel;
              st_next.meas = eb_mix(eb_mix(EB_LOG_SEED, st_reg.base),
                st_reg.size ^ st_reg.ssa);
              st_next.attr_init = 1'b0;
              st_next.life = EB_LC_BUILDING;
            end
          end
          EB_OP_ADD:
          begin
            if (st_reg.life == EB_LC_INITED)
              st_next.err = EB_ERR_INITED;
            else if (st_reg.life != EB_LC_BUILDING)
              st_next.err = EB_ERR_STATE;
            else if (cur.valid || (new_ent.ptype != EB_TYPE_REG &&
              new_ent.ptype != EB_TYPE_THREAD) ||
              st_reg.lin_addr < st_reg.base ||
              st_reg.lin_addr - st_reg.base >= st_reg.size)
              st_next.err = EB_ERR_PAGE;
            else
            begin
              map.we = 1'b1;
              st_next.meas = eb_mix(st_reg.meas, {new_ent.lin_page,
                1'b0, new_ent.perm, new_ent.ptype[7:0]} ^
                32'(st_reg.ctrl_page));
              st_next.copy_req = 1'b1;
              st_next.copy_src = st_reg.src_addr;
              st_next.copy_page = st_reg.page_sel;
            end
          end
          EB_OP_EXTEND:
          begin
            if (st_reg.life == EB_LC_INITED)
              st_next.err = EB_ERR_INITED;
            else if (st_reg.life != EB_LC_BUILDING)
              st_next.err = EB_ERR_STATE;
            else if (!cur.valid || cur.ptype == EB_TYPE_CTRL)
              st_next.err = EB_ERR_PAGE;
            else
            begin
              // region identity: page address plus 256-byte offset
              st_next.meas = eb_mix(eb_mix(st_reg.meas,
                {cur.lin_page, st_reg.lin_addr[11:8], 8'h0}),
                st_reg.ext_data);
            end
          end
          EB_OP_INIT:
          begin
            if (st_reg.life != EB_LC_BUILDING)
              st_next.err = EB_ERR_STATE;
            else if (st_reg.sig_sign !=
              eb_mix(st_reg.sig_key, st_reg.sig_hash))
              st_next.err = EB_ERR_SIGN;
            else if (final_meas != st_reg.sig_hash)
              st_next.err = EB_ERR_MEAS;
            else if (st_reg.attr != st_reg.sig_attr ||
              st_reg.misc != st_reg.sig_misc)
              st_next.err = EB_ERR_ATTR;
            else if (st_reg.token != (PLATFORM_KEY ^ st_reg.sig_hash))
              st_next.err = EB_ERR_TOKEN;
            else
            begin
              st_next.meas = final_meas;
              st_next.ident = final_meas;
              st_next.auth = eb_mix(st_reg.sig_key, EB_FINAL_K);
              st_next.rec_prodid = st_reg.prodid;
              st_next.rec_svn = st_reg.svn;
              st_next.life = EB_LC_INITED;
              st_next.attr_init = 1'b1;
            end
          end
          EB_OP_ENTER:
          begin
            if (st_reg.life != EB_LC_INITED)
              st_next.err = EB_ERR_ENTER;
            else
              st_next.entered = 1'b1;
          end
          default:
            st_next.err = EB_ERR_OP;
        endcase
      end
      default:
        st_next.state = EB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign dat_o = st_reg.rdat;
  assign ack_o = st_reg.ack;
  assign copy_req_o = st_reg.copy_req;
  assign copy_src_o = st_reg.copy_src;
  assign copy_page_o = st_reg.copy_page;

endmodule

// file: verilog/eb_map_if.sv
`timescale 1ns/1ps
interface eb_map_if #(parameter int AW = 6, parameter int W = 36);
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport owner (output we, output waddr, output wdata, output raddr,
    input rdata);
  modport store (input we, input waddr, input wdata, input raddr,
    output rdata);
endinterface

// file: verilog/eb_page_map.sv
`timescale 1ns/1ps
module eb_page_map #(
  parameter int AW = 6,
  parameter int W = 36
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // access port
  eb_map_if.store map
);
  localparam int DEPTH = 1 << AW;

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } eb_pm_s;

  eb_pm_s st_reg;
  eb_pm_s st_next;

  // read returns the old word on a same-address write
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = st_reg.mem[map.raddr];
    if (map.we)
    begin
      st_next.mem[map.waddr] = map.wdata;
    end
  end

  // reset clears every entry so all pages start free
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign map.rdata = st_reg.rdata;
endmodule

// file: verilog/eb_pkg.sv
package eb_pkg;

  // register byte offsets
  localparam logic [7:0] EB_CTRL_OFS = 8'h00;
  localparam logic [7:0] EB_STAT_OFS = 8'h04;
  localparam logic [7:0] EB_PAGE_SEL_OFS = 8'h08;
  localparam logic [7:0] EB_PAGE_ARG_OFS = 8'h0c;
  localparam logic [7:0] EB_LIN_ADDR_OFS = 8'h10;
  localparam logic [7:0] EB_SRC_ADDR_OFS = 8'h14;
  localparam logic [7:0] EB_BASE_OFS = 8'h18;
  localparam logic [7:0] EB_SIZE_OFS = 8'h1c;
  localparam logic [7:0] EB_ATTR_OFS = 8'h20;
  localparam logic [7:0] EB_MISC_OFS = 8'h24;
  localparam logic [7:0] EB_SSA_OFS = 8'h28;
  localparam logic [7:0] EB_EXT_DATA_OFS = 8'h2c;
  localparam logic [7:0] EB_SIG_KEY_OFS = 8'h30;
  localparam logic [7:0] EB_SIG_HASH_OFS = 8'h34;
  localparam logic [7:0] EB_SIG_ATTR_OFS = 8'h38;
  localparam logic [7:0] EB_SIG_MISC_OFS = 8'h3c;
  localparam logic [7:0] EB_SIG_SIGN_OFS = 8'h40;
  localparam logic [7:0] EB_TOKEN_OFS = 8'h44;
  localparam logic [7:0] EB_PRODID_OFS = 8'h48;
  localparam logic [7:0] EB_SVN_OFS = 8'h4c;
  localparam logic [7:0] EB_MEAS_OFS = 8'h50;
  localparam logic [7:0] EB_IDENT_OFS = 8'h54;
  localparam logic [7:0] EB_AUTH_OFS = 8'h58;
  localparam logic [7:0] EB_INFO_LO_OFS = 8'h5c;
  localparam logic [7:0] EB_INFO_HI_OFS = 8'h60;

  // page status word field positions
  localparam int EB_INFO_R_BIT = 0;
  localparam int EB_INFO_W_BIT = 1;
  localparam int EB_INFO_X_BIT = 2;
  localparam int EB_INFO_PEND_BIT = 3;
  localparam int EB_INFO_MOD_BIT = 4;
  localparam int EB_INFO_RSTR_BIT = 5;
  localparam int EB_INFO_TYPE_LSB = 8;
  localparam int EB_INFO_BLK_BIT = 63;

  // page type codes
  localparam logic [7:0] EB_TYPE_CTRL = 8'h00;
  localparam logic [7:0] EB_TYPE_THREAD = 8'h01;
  localparam logic [7:0] EB_TYPE_REG = 8'h02;

  // region layout
  localparam int EB_CHUNK_BYTES = 256;
  localparam int EB_PAGE_BYTES = 4096;
  localparam int EB_CHUNKS = EB_PAGE_BYTES / EB_CHUNK_BYTES;

  // mixing constants, arbitrary values
  localparam logic [31:0] EB_LOG_SEED = 32'h6a09e667;
  localparam logic [31:0] EB_MIX_K = 32'h9e3779b9;
  localparam logic [31:0] EB_FINAL_K = 32'hbb67ae85;

  // error codes
  localparam logic [3:0] EB_ERR_NONE = 4'h0;
  localparam logic [3:0] EB_ERR_STATE = 4'h1;
  localparam logic [3:0] EB_ERR_PAGE = 4'h2;
  localparam logic [3:0] EB_ERR_INITED = 4'h3;
  localparam logic [3:0] EB_ERR_SIGN = 4'h4;
  localparam logic [3:0] EB_ERR_MEAS = 4'h5;
  localparam logic [3:0] EB_ERR_ATTR = 4'h6;
  localparam logic [3:0] EB_ERR_TOKEN = 4'h7;
  localparam logic [3:0] EB_ERR_ENTER = 4'h8;
  localparam logic [3:0] EB_ERR_OP = 4'h9;

  typedef enum logic [2:0]
  {
    EB_OP_NONE = 3'h0,
    EB_OP_CREATE = 3'h1,
    EB_OP_ADD = 3'h2,
    EB_OP_EXTEND = 3'h3,
    EB_OP_INIT = 3'h4,
    EB_OP_ENTER = 3'h5
  } eb_op_e;

  typedef enum logic [1:0]
  {
    EB_LC_EMPTY = 2'h0,
    EB_LC_BUILDING = 2'h1,
    EB_LC_INITED = 2'h2
  } eb_life_e;

  typedef enum logic [1:0]
  {
    EB_ST_IDLE = 2'h0,
    EB_ST_SETTLE = 2'h1,
    EB_ST_EXEC = 2'h2
  } eb_state_e;

  typedef struct packed
  {
    logic valid;
    logic blocked;
    logic restricted;
    logic modified;
    logic pending;
    logic [2:0] perm;
    logic [7:0] ptype;
    logic [19:0] lin_page;
  } eb_map_entry_s;

  localparam int EB_ENTRY_W = $bits(eb_map_entry_s);

  // one log step, not a real cryptographic hash
  function automatic logic [31:0] eb_mix(logic [31:0] acc, logic [31:0] din);
    eb_mix = {acc[26:0], acc[31:27]} ^ din ^ EB_MIX_K;
  endfunction

endpackage
